/* include/gpp_pkg.sv */
package gpp_pkg;
  localparam int          GPP_WIDTH       = 8;
  localparam logic [3:0]  GPP_OFS_DATA    = 4'h0;
  localparam logic [3:0]  GPP_OFS_DIR     = 4'h1;
  localparam logic [3:0]  GPP_OFS_PULL    = 4'h2;
  localparam logic [3:0]  GPP_OFS_SLEW    = 4'h3;
  localparam logic [3:0]  GPP_OFS_DRIVE   = 4'h4;
  localparam logic [3:0]  GPP_OFS_STATCTL = 4'h5;
  localparam logic [3:0]  GPP_OFS_SRCSEL  = 4'h6;
  localparam logic [3:0]  GPP_OFS_POLSEL  = 4'h7;
  localparam logic [3:0]  GPP_OFS_IRQSTAT = 4'h8;
  localparam logic [3:0]  GPP_OFS_IRQMASK = 4'h9;
  localparam int          GPP_BIT_FLAG    = 3;
  localparam int          GPP_BIT_ACK     = 2;
  localparam int          GPP_BIT_IE      = 1;
  localparam int          GPP_BIT_MOD     = 0;
  localparam int          GPP_EVT_DETECT  = 0;
  localparam int          GPP_EVT_ACKHOLD = 1;
  localparam logic [7:0]  GPP_RST_REG     = 8'h00;
  localparam logic [7:0]  GPP_RST_SLEW    = 8'h00;
  localparam logic [1:0]  GPP_RST_EVT     = 2'h0;
  localparam int          GPP_SYNC_STAGES = 2;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpp_req_t;

  typedef struct packed {
    logic [7:0] out_val;
    logic [7:0] out_en_n;
    logic [7:0] pull_en;
    logic [7:0] pull_down;
    logic [7:0] slew_en;
    logic [7:0] drive_hi;
  } gpp_pad_t;
endpackage : gpp_pkg

/* core/gpp_sync.sv */
`timescale 1ns/100ps
module gpp_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // two flops; only the second stage is visible outside
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;
endmodule : gpp_sync

/* core/gpp_detect.sv */
`timescale 1ns/100ps
module gpp_detect #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_sync,
  input  wire logic [WIDTH-1:0] src_sel,
  input  wire logic [WIDTH-1:0] pol_sel,
  output logic      [WIDTH-1:0] edge_hit,
  output logic      [WIDTH-1:0] level_hit
);
  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] act;
  logic [WIDTH-1:0] act_prev;

  // history of the synchronised level for edge detection
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= pin_sync;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
      // polarity folds to active-high so one edge test fits both senses
      assign act[gi]       = pol_sel[gi] ? pin_sync[gi] : ~pin_sync[gi];
      assign act_prev[gi]  = pol_sel[gi] ? prev_ff[gi]  : ~prev_ff[gi];
      assign edge_hit[gi]  = src_sel[gi] & act[gi] & ~act_prev[gi];
      assign level_hit[gi] = src_sel[gi] & act[gi];
    end
  endgenerate
endmodule : gpp_detect

/* core/gpp_port.sv */
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
module gpp_port #(
  parameter int WIDTH = gpp_pkg::GPP_WIDTH
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n,
  output logic      [WIDTH-1:0] pull_en,
  output logic      [WIDTH-1:0] pull_down,
  output logic      [WIDTH-1:0] slew_en,
  output logic      [WIDTH-1:0] drive_hi,
  output logic                  pin_irq_req,
  output logic                  irq
);
  gpp_pkg::gpp_req_t req;
  gpp_pkg::gpp_pad_t pad;

  logic [WIDTH-1:0] port_data_latch_ff;
  logic [WIDTH-1:0] pin_direction_ff;
  logic [WIDTH-1:0] pull_enable_ff;
  logic [WIDTH-1:0] slew_limit_enable_ff;
  logic [WIDTH-1:0] drive_strength_select_ff;
  logic [WIDTH-1:0] pin_irq_source_select_ff;
  logic [WIDTH-1:0] pin_irq_polarity_select_ff;
  logic             pin_irq_flag_ff;
  logic             pin_irq_enable_ff;
  logic             detect_mode_select_ff;
  logic [1:0]       evt_status_ff;
  logic [1:0]       evt_mask_ff;
  logic [7:0]       rdata_ff;
  logic [7:0]       nxt_rdata;
  logic [WIDTH-1:0] pin_sync;
  logic [WIDTH-1:0] edge_hit;
  logic [WIDTH-1:0] level_hit;
  logic             detect;
  logic             level_active;
  logic             pin_irq_acknowledge;
  logic             ack_blocked;
  logic             wr_data;
  logic             wr_dir;
  logic             wr_pull;
  logic             wr_slew;
  logic             wr_drive;
  logic             wr_sc;
  logic             wr_src;
  logic             wr_pol;
  logic             wr_stat;
  logic             wr_mask;

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  // write decode
  assign wr_data = req.wr && (req.addr == gpp_pkg::GPP_OFS_DATA);
  assign wr_dir  = req.wr && (req.addr == gpp_pkg::GPP_OFS_DIR);
  assign wr_pull = req.wr && (req.addr == gpp_pkg::GPP_OFS_PULL);
  assign wr_slew = req.wr && (req.addr == gpp_pkg::GPP_OFS_SLEW);
  assign wr_drive = req.wr && (req.addr == gpp_pkg::GPP_OFS_DRIVE);
  assign wr_sc   = req.wr && (req.addr == gpp_pkg::GPP_OFS_STATCTL);
  assign wr_src  = req.wr && (req.addr == gpp_pkg::GPP_OFS_SRCSEL);
  assign wr_pol  = req.wr && (req.addr == gpp_pkg::GPP_OFS_POLSEL);
  assign wr_stat = req.wr && (req.addr == gpp_pkg::GPP_OFS_IRQSTAT);
  assign wr_mask = req.wr && (req.addr == gpp_pkg::GPP_OFS_IRQMASK);

  // pins cross into the bus clock before any detection
  gpp_sync #(
    .WIDTH (WIDTH)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  gpp_detect #(
    .WIDTH (WIDTH)
  ) u_detect (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_sync  (pin_sync),
    .src_sel   (pin_irq_source_select_ff),
    .pol_sel   (pin_irq_polarity_select_ff),
    .edge_hit  (edge_hit),
    .level_hit (level_hit)
  );

  // data latch takes every write whatever the direction
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_data_latch_ff <= '0;
    end else if (wr_data) begin
      port_data_latch_ff <= req.wdata[WIDTH-1:0];
    end
  end

  // pin configuration registers; all inputs, no pulls after reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_direction_ff         <= '0;
      pull_enable_ff           <= '0;
      drive_strength_select_ff <= '0;
    end else begin
      if (wr_dir) begin
        pin_direction_ff <= req.wdata[WIDTH-1:0];
      end
      if (wr_pull) begin
        pull_enable_ff <= req.wdata[WIDTH-1:0];
      end
      if (wr_drive) begin
        drive_strength_select_ff <= req.wdata[WIDTH-1:0];
      end
    end
  end

  // slew reset value is not something software should rely on
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slew_limit_enable_ff <= gpp_pkg::GPP_RST_SLEW[WIDTH-1:0];
    end else if (wr_slew) begin
      slew_limit_enable_ff <= req.wdata[WIDTH-1:0];
    end
  end

  // interrupt source and polarity selects
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_irq_source_select_ff   <= '0;
      pin_irq_polarity_select_ff <= '0;
    end else begin
      if (wr_src) begin
        pin_irq_source_select_ff <= req.wdata[WIDTH-1:0];
      end
      if (wr_pol) begin
        pin_irq_polarity_select_ff <= req.wdata[WIDTH-1:0];
      end
    end
  end

  // enable and mode bits of the status/control register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_irq_enable_ff     <= 1'b0;
      detect_mode_select_ff <= 1'b0;
    end else if (wr_sc) begin
      pin_irq_enable_ff     <= req.wdata[gpp_pkg::GPP_BIT_IE];
      detect_mode_select_ff <= req.wdata[gpp_pkg::GPP_BIT_MOD];
    end
  end

  // level mode also fires on a held level, not only a transition
  assign level_active        = |level_hit;
  assign detect              = (|edge_hit) | (detect_mode_select_ff & level_active);
  assign pin_irq_acknowledge = wr_sc & req.wdata[gpp_pkg::GPP_BIT_ACK];
  assign ack_blocked         = pin_irq_acknowledge & detect_mode_select_ff & level_active;

  // flag: detection wins over a same-cycle acknowledge; data bit 3 is ignored
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_irq_flag_ff <= 1'b0;
    end else if (detect) begin
      pin_irq_flag_ff <= 1'b1;
    end else if (pin_irq_acknowledge) begin
      pin_irq_flag_ff <= 1'b0;
    end
  end

  // sticky event status, write one to clear, set beats clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      evt_status_ff <= gpp_pkg::GPP_RST_EVT;
    end else begin
      evt_status_ff[gpp_pkg::GPP_EVT_DETECT] <= detect |
        (evt_status_ff[gpp_pkg::GPP_EVT_DETECT] & ~(wr_stat & req.wdata[gpp_pkg::GPP_EVT_DETECT]));
      evt_status_ff[gpp_pkg::GPP_EVT_ACKHOLD] <= ack_blocked |
        (evt_status_ff[gpp_pkg::GPP_EVT_ACKHOLD] & ~(wr_stat & req.wdata[gpp_pkg::GPP_EVT_ACKHOLD]));
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      evt_mask_ff <= gpp_pkg::GPP_RST_EVT;
    end else if (wr_mask) begin
      evt_mask_ff <= req.wdata[1:0];
    end
  end

  // read mux; input bits show the pin, output bits the latch
  always_comb begin
    nxt_rdata = gpp_pkg::GPP_RST_REG;
    case (req.addr)
      gpp_pkg::GPP_OFS_DATA:    nxt_rdata[WIDTH-1:0] = (pin_direction_ff & port_data_latch_ff) |
                                                       (~pin_direction_ff & pin_sync);
      gpp_pkg::GPP_OFS_DIR:     nxt_rdata[WIDTH-1:0] = pin_direction_ff;
      gpp_pkg::GPP_OFS_PULL:    nxt_rdata[WIDTH-1:0] = pull_enable_ff;
      gpp_pkg::GPP_OFS_SLEW:    nxt_rdata[WIDTH-1:0] = slew_limit_enable_ff;
      gpp_pkg::GPP_OFS_DRIVE:   nxt_rdata[WIDTH-1:0] = drive_strength_select_ff;
      gpp_pkg::GPP_OFS_STATCTL: begin
        nxt_rdata[gpp_pkg::GPP_BIT_FLAG] = pin_irq_flag_ff;
        nxt_rdata[gpp_pkg::GPP_BIT_ACK]  = 1'b0;
        nxt_rdata[gpp_pkg::GPP_BIT_IE]   = pin_irq_enable_ff;
        nxt_rdata[gpp_pkg::GPP_BIT_MOD]  = detect_mode_select_ff;
      end
      gpp_pkg::GPP_OFS_SRCSEL:  nxt_rdata[WIDTH-1:0] = pin_irq_source_select_ff;
      gpp_pkg::GPP_OFS_POLSEL:  nxt_rdata[WIDTH-1:0] = pin_irq_polarity_select_ff;
      gpp_pkg::GPP_OFS_IRQSTAT: nxt_rdata[1:0] = evt_status_ff;
      gpp_pkg::GPP_OFS_IRQMASK: nxt_rdata[1:0] = evt_mask_ff;
      default:                  nxt_rdata = gpp_pkg::GPP_RST_REG;
    endcase
  end

  // read data holds only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_ff <= gpp_pkg::GPP_RST_REG;
    end else if (req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= gpp_pkg::GPP_RST_REG;
    end
  end

  // pad controls; output pins drop their pull and inputs ignore slew/drive
  assign pad.out_val   = port_data_latch_ff;
  assign pad.out_en_n  = ~pin_direction_ff;
  assign pad.pull_en   = pull_enable_ff & ~pin_direction_ff;
  assign pad.pull_down = pull_enable_ff & ~pin_direction_ff & pin_irq_source_select_ff &
                         pin_irq_polarity_select_ff;
  assign pad.slew_en   = slew_limit_enable_ff & pin_direction_ff;
  assign pad.drive_hi  = drive_strength_select_ff & pin_direction_ff;

  assign pin_out     = pad.out_val;
  assign pin_oe_n    = pad.out_en_n;
  assign pull_en     = pad.pull_en;
  assign pull_down   = pad.pull_down;
  assign slew_en     = pad.slew_en;
  assign drive_hi    = pad.drive_hi;
  assign reg_rdata   = rdata_ff;
  assign pin_irq_req = pin_irq_enable_ff & pin_irq_flag_ff;
  assign irq         = |(evt_status_ff & evt_mask_ff);

  AST_REQ_FOLLOWS_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
    pin_irq_req == (pin_irq_enable_ff && pin_irq_flag_ff))
    else $error("request does not follow enable and flag");

  AST_EDGE_SETS_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
    (|edge_hit) |=> pin_irq_flag_ff)
    else $error("edge did not set flag");

  AST_ACK_CLEARS: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_irq_acknowledge && !detect) |=> !pin_irq_flag_ff)
    else $error("acknowledge did not clear flag");

  AST_ACK_READS_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    (req.rd && req.addr == gpp_pkg::GPP_OFS_STATCTL) |=> !reg_rdata[gpp_pkg::GPP_BIT_ACK])
    else $error("ack bit read as one");

  AST_FLAG_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_sc && req.wdata[gpp_pkg::GPP_BIT_FLAG] && !detect && !pin_irq_flag_ff) |=> !pin_irq_flag_ff)
    else $error("write set the flag");

  AST_LEVEL_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)
    (detect_mode_select_ff && level_active && pin_irq_acknowledge) |=> pin_irq_flag_ff)
    else $error("level mode ack cleared an active flag");

  AST_UNSELECTED_QUIET: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_irq_source_select_ff == '0 && !pin_irq_flag_ff && !wr_src) |=> !pin_irq_flag_ff)
    else $error("flag set with no source selected");

  AST_OUTPUT_NO_PULL: assert property (@(posedge clk) disable iff (!reset_n)
    (pull_en & pin_direction_ff) == '0 && (slew_en & ~pin_direction_ff) == '0)
    else $error("pull on output pin or slew on input");

  AST_INPUT_READ: assert property (@(posedge clk) disable iff (!reset_n)
    (req.rd && req.addr == gpp_pkg::GPP_OFS_DATA && !wr_dir) |=>
      reg_rdata[WIDTH-1:0] == ((pin_direction_ff & port_data_latch_ff) | (~pin_direction_ff & $past(pin_sync))))
    else $error("data read mismatch");

  AST_PULLDOWN_SCOPE: assert property (@(posedge clk) disable iff (!reset_n)
    (pull_down & ~(pin_irq_source_select_ff & pin_irq_polarity_select_ff)) == '0)
    else $error("pull-down outside interrupt use");

  // pad-side invariants; these catch a broken pad mapping even when no test reads it back
  AST_OE_FOLLOWS_DIR: assert property (@(posedge clk) disable iff (!reset_n)
    pin_oe_n == ~pin_direction_ff)
    else $error("output enable does not follow direction");

  AST_PIN_OUT_LATCH: assert property (@(posedge clk) disable iff (!reset_n)
    pin_out == port_data_latch_ff)
    else $error("pin output differs from data latch");

  AST_DRIVE_INPUT_IGNORED: assert property (@(posedge clk) disable iff (!reset_n)
    (drive_hi & ~pin_direction_ff) == '0)
    else $error("high drive on an input pin");

  AST_PULL_FOLLOWS_ENABLE: assert property (@(posedge clk) disable iff (!reset_n)
    pull_en == (pull_enable_ff & ~pin_direction_ff))
    else $error("pull enable does not follow register");

  AST_SLEW_ON_OUTPUT: assert property (@(posedge clk) disable iff (!reset_n)
    slew_en == (slew_limit_enable_ff & pin_direction_ff))
    else $error("slew limit does not follow register");

  AST_PULLDOWN_NEEDS_PULL: assert property (@(posedge clk) disable iff (!reset_n)
    (pull_down & ~pull_en) == '0)
    else $error("pull-down without pull enable");

  // interrupt-side invariants
  AST_LEVEL_SETS_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
    (detect_mode_select_ff && level_active) |=> pin_irq_flag_ff)
    else $error("held level did not set flag");

  AST_FLAG_ONLY_ON_DETECT: assert property (@(posedge clk) disable iff (!reset_n)
    (!detect && !pin_irq_flag_ff) |=> !pin_irq_flag_ff)
    else $error("flag set without detection");

  AST_LEVEL_NEEDS_SOURCE: assert property (@(posedge clk) disable iff (!reset_n)
    (level_hit & ~pin_irq_source_select_ff) == '0)
    else $error("unselected pin reported active");

  AST_REQ_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (!reset_n)
    !pin_irq_enable_ff |-> !pin_irq_req)
    else $error("request with interrupt disabled");

  // reset is synchronous, so the pad state is checked one edge after it is sampled
  AST_RESET_STATE: assert property (@(posedge clk)
    !reset_n |=> (pin_oe_n == '1 && pin_out == '0 && pull_en == '0 && !pin_irq_req))
    else $error("pad state wrong after reset");
endmodule : gpp_port

/* verification/gpp_pin_model.sv */
`timescale 1ns/100ps
// stands in for the board: a pad is driven by the port, by the test, by a pull, or left floating
module gpp_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pull_en,
  input  wire logic [7:0] pull_down,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  logic [7:0] float_ff = 8'h55;

  // an undriven, unpulled pad toggles every cycle so a stale level never passes for a real one
  always @(posedge clk) begin
    float_ff <= ~float_ff;
  end

  // the port driver wins, then the board driver, then the pull device, then nothing
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pull_en[i])
        pin_in[i] = ~pull_down[i];
      else
        pin_in[i] = float_ff[i];
    end
  end
endmodule : gpp_pin_model

/* verification/test_gpp_port.sv */
`timescale 1ns/100ps
module test_gpp_port;
  logic       clk = 1'b0;
  logic       reset_n;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic [7:0] pull_en;
  logic [7:0] pull_down;
  logic [7:0] slew_en;
  logic [7:0] drive_hi;
  logic       pin_irq_req;
  logic       irq;
  logic [7:0] ext_en;
  logic [7:0] ext_val;
  int         n_fail;
  int         comparisons;
  int         cycles = 0;

  gpp_port uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pull_en(pull_en), .pull_down(pull_down), .slew_en(slew_en), .drive_hi(drive_hi),
    .pin_irq_req(pin_irq_req), .irq(irq));

  gpp_pin_model pads (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
    .pull_down(pull_down), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // 125 MHz
  always #4 clk = ~clk;

  // a hang ends the run as a failure instead of stalling the regression
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write strobe; a cycle of gap follows so the strobe is never assigned twice at one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stands only in the cycle after the strobe, so it is sampled there
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd_chk

  // pad change reaches the flag three edges later through the synchroniser
  task automatic set_pins(input logic [7:0] v);
    @(posedge clk);
    ext_val <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask : set_pins

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
  endtask : do_reset

  task automatic t_reset();
    check(pin_oe_n, 8'hFF);
    check(pin_out, 8'h00);
    check(pull_en, 8'h00);
    check({6'h00, pin_irq_req, irq}, 8'h00);
    for (int a = 0; a < 10; a++) begin
      rd_chk(a[3:0], 8'h00);
    end
    rd_chk(4'hA, 8'h00);
    wr(gpp_pkg::GPP_OFS_SLEW, 8'h00);
  endtask : t_reset

  task automatic t_direction();
    set_pins(8'h3C);
    wr(gpp_pkg::GPP_OFS_DATA, 8'hA5);
    wr(gpp_pkg::GPP_OFS_DIR, 8'hF0);
    check(pin_oe_n, 8'h0F);
    check(pin_out, 8'hA5);
    rd_chk(gpp_pkg::GPP_OFS_DATA, 8'hAC);
    rd_chk(gpp_pkg::GPP_OFS_DIR, 8'hF0);
    wr(gpp_pkg::GPP_OFS_DATA, 8'h5A);
    check(pin_out, 8'h5A);
    rd_chk(gpp_pkg::GPP_OFS_DATA, 8'h5C);
  endtask : t_direction

  task automatic t_pads();
    wr(gpp_pkg::GPP_OFS_PULL, 8'hFF);
    wr(gpp_pkg::GPP_OFS_SLEW, 8'hFF);
    wr(gpp_pkg::GPP_OFS_DRIVE, 8'h55);
    check(pull_en, 8'h0F);
    check(slew_en, 8'hF0);
    check(drive_hi, 8'h50);
    check(pull_down, 8'h00);
    wr(gpp_pkg::GPP_OFS_SRCSEL, 8'h13);
    wr(gpp_pkg::GPP_OFS_POLSEL, 8'h16);
    check(pull_down, 8'h02);
    // release the board on the low nibble so only the pull devices set those pins
    @(posedge clk);
    ext_en <= 8'hF0;
    repeat (3) @(posedge clk);
    #1;
    rd_chk(gpp_pkg::GPP_OFS_DATA, 8'h5D);
    @(posedge clk);
    ext_en <= 8'hFF;
    rd_chk(gpp_pkg::GPP_OFS_DRIVE, 8'h55);
  endtask : t_pads

  task automatic t_edge();
    do_reset();
    set_pins(8'h00);
    wr(gpp_pkg::GPP_OFS_IRQMASK, 8'h03);
    wr(gpp_pkg::GPP_OFS_SRCSEL, 8'h01);
    wr(gpp_pkg::GPP_OFS_POLSEL, 8'h01);
    wr(gpp_pkg::GPP_OFS_STATCTL, 8'h02);
    set_pins(8'h02);
    rd_chk(gpp_pkg::GPP_OFS_STATCTL, 8'h02);
    set_pins(8'h03);
    check({7'h00, pin_irq_req}, 8'h01);
    check({7'h00, irq}, 8'h01);
    rd_chk(gpp_pkg::GPP_OFS_STATCTL, 8'h0A);
    rd_chk(gpp_pkg::GPP_OFS_IRQSTAT, 8'h01);
    wr(gpp_pkg::GPP_OFS_STATCTL, 8'h06);
    rd_chk(gpp_pkg::GPP_OFS_STATCTL, 8'h02);
    repeat (8) @(posedge clk);
    check({7'h00, pin_irq_req}, 8'h00);
    wr(gpp_pkg::GPP_OFS_STATCTL, 8'h0A);
    rd_chk(gpp_pkg::GPP_OFS_STATCTL, 8'h02);
    wr(gpp_pkg::GPP_OFS_STATCTL, 8'h00);
    set_pins(8'h02);
    set_pins(8'h03);
    rd_chk(gpp_pkg::GPP_OFS_STATCTL, 8'h08);
    check({7'h00, pin_irq_req}, 8'h00);
    wr(gpp_pkg::GPP_OFS_IRQSTAT, 8'h01);
    rd_chk(gpp_pkg::GPP_OFS_IRQSTAT, 8'h00);
    check({7'h00, irq}, 8'h00);
  endtask : t_edge

  task automatic t_level();
    do_reset();
    set_pins(8'h04);
    wr(gpp_pkg::GPP_OFS_SRCSEL, 8'h04);
    wr(gpp_pkg::GPP_OFS_POLSEL, 8'h00);
    wr(gpp_pkg::GPP_OFS_STATCTL, 8'h03);
    wr(gpp_pkg::GPP_OFS_IRQMASK, 8'h02);
    set_pins(8'h00);
    check({7'h00, pin_irq_req}, 8'h01);
    check({7'h00, irq}, 8'h00);
    wr(gpp_pkg::GPP_OFS_STATCTL, 8'h07);
    rd_chk(gpp_pkg::GPP_OFS_STATCTL, 8'h0B);
    rd_chk(gpp_pkg::GPP_OFS_IRQSTAT, 8'h03);
    check({7'h00, irq}, 8'h01);
    wr(gpp_pkg::GPP_OFS_IRQSTAT, 8'h03);
    check({7'h00, irq}, 8'h00);
    set_pins(8'h04);
    wr(gpp_pkg::GPP_OFS_STATCTL, 8'h07);
    rd_chk(gpp_pkg::GPP_OFS_STATCTL, 8'h03);
  endtask : t_level

  initial begin
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_en = 8'hFF;
    ext_val = 8'h00;
    n_fail = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    t_reset();
    t_direction();
    t_pads();
    t_edge();
    t_level();
    complete_run();
  end
endmodule : test_gpp_port
